// *** src/irq_vector_logic.sv ***
/*
  Interrupt flags, local enables, priority encoder and the entry sequence
  (finish, stack, mask, two-byte vector fetch) toward the processor core.
  Assumes sources give one-cycle event pulses, the core answers memory
  accesses in the same cycle and reports instruction boundaries.
*/
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Vector is two bytes; high address byte at lower address, low at next.
// RULE2: A source event sets its flag whatever the local enable.
// RULE3: Request goes forward only while flag and local enable are both one.
// RULE4: Request accepted only with global mask clear, after current instruction.
// RULE5: Stack program counter low, high, index, accumulator, condition codes.
// RULE6: After stacking set global mask, then fetch vector of top pending source.
// RULE7: Execution resumes at address read from the selected vector entry.
// RULE8: Smallest vector number wins; zero highest, thirty-one lowest.
// RULE9: Vectors 31 to 24 sit lowest in the table and have no source.
// RULE10: Fixed source to vector number map; other numbers unused.
// RULE11: Vector 0 serves all enabled reset causes.
// RULE12: Global mask comes up set after any reset.
// RULE13: Software trap has no enable and ignores the global mask.
module irq_vector_logic
  import irq_vector_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_SOURCES-1:0] source_event,
  input wire logic software_trap,
  input wire logic instr_boundary,
  input wire logic mask_clear,
  input wire logic watchdog_expired,
  input wire logic watchdog_enable,
  input wire logic low_voltage_trip,
  input wire logic low_voltage_reset_enable,
  input wire logic reset_pin,
  input wire logic reset_pin_enable,
  input wire logic illegal_opcode,
  input wire logic illegal_address,
  input wire logic power_on,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic mem_read,
  output logic mem_write,
  output logic [2:0] stack_select,
  output logic [15:0] program_counter,
  output logic pc_load,
  output logic global_mask,
  output logic irq_request,
  output logic system_reset,
  output logic irq
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [15:0] vector_address(input logic [4:0] num);
    logic [15:0] off;
    off = {10'h000, ~num, 1'b0};
    vector_address = VECTOR_BASE + off; // RULE9
  endfunction

  // Source index to vector number
  function automatic logic [4:0] source_vector(input int idx);
    logic [4:0] v;
    v = VEC_RESET;
    unique case (idx)
      0: v = VEC_PERIODIC_WAKEUP;
      1: v = VEC_CONVERSION;
      2: v = VEC_KEYPAD;
      3: v = VEC_TIMER_TWO_OVF;
      4: v = VEC_TIMER_TWO_CH0;
      5: v = VEC_TIMER_ONE_OVF;
      6: v = VEC_TIMER_ONE_CH1;
      7: v = VEC_TIMER_ONE_CH0;
      8: v = VEC_REQUEST_PIN;
      default: v = VEC_LOW_VOLTAGE;
    endcase
    source_vector = v; // RULE10
  endfunction

  // ************************************************************
  // Flags, enables and reset collection
  // ************************************************************
  logic [NUM_SOURCES-1:0] flags_q;
  logic [NUM_SOURCES-1:0] enables_q;
  logic [NUM_SOURCES-1:0] pending;
  logic [NUM_SOURCES-1:0] flag_clear;
  logic trap_q;
  logic mask_q;
  logic [4:0] best_vec;
  logic any_pending;
  logic [4:0] sel_vec_q;
  logic [7:0] status_q;
  logic [7:0] mask_reg_q;
  seq_state_type state_q;
  logic [2:0] stack_cnt_q;
  logic [7:0] vec_high_q;
  logic reset_cause;

  assign reset_cause = (watchdog_expired && watchdog_enable) || (low_voltage_trip && low_voltage_reset_enable)
    || (reset_pin && reset_pin_enable) || illegal_opcode || illegal_address || power_on; // RULE11
  assign system_reset = reset_cause;

  always_comb begin
    flag_clear = '0;
    if (reg_write && reg_addr == REG_FLAGS_LO) begin
      flag_clear[7:0] = reg_wdata;
    end
    if (reg_write && reg_addr == REG_FLAGS_HI) begin
      flag_clear[9:8] = reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || reset_cause) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= (flags_q & ~flag_clear) | source_event; // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (rst || reset_cause) begin
      enables_q <= ENABLES_RESET;
    end else if (reg_write && reg_addr == REG_ENABLE_LO) begin
      enables_q[7:0] <= reg_wdata;
    end else if (reg_write && reg_addr == REG_ENABLE_HI) begin
      enables_q[9:8] <= reg_wdata[1:0];
    end
  end

  assign pending = flags_q & enables_q; // RULE3

  // Smallest vector number among pending sources
  always_comb begin
    best_vec = 5'h1f;
    any_pending = 1'b0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (pending[i] && (!any_pending || source_vector(i) < best_vec)) begin
        best_vec = source_vector(i); // RULE8
        any_pending = 1'b1;
      end
    end
    if (trap_q) begin
      best_vec = VEC_SOFTWARE_TRAP; // RULE8
      any_pending = 1'b1;
    end
  end

  assign irq_request = |pending; // RULE3

  // ************************************************************
  // Global mask and trap latch
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst || reset_cause) begin
      mask_q <= GLOBAL_MASK_RESET; // RULE12
    end else if (state_q == ST_STACK && stack_cnt_q == STACK_CCR) begin
      mask_q <= 1'b1; // RULE6
    end else if (mask_clear) begin
      mask_q <= 1'b0;
    end
  end
  assign global_mask = mask_q;

  always_ff @(posedge clk) begin
    if (rst || reset_cause) begin
      trap_q <= 1'b0;
    end else if (software_trap) begin
      trap_q <= 1'b1;
    end else if (state_q == ST_FETCH_HIGH && sel_vec_q == VEC_SOFTWARE_TRAP) begin
      trap_q <= 1'b0;
    end
  end

  // ************************************************************
  // Entry sequence
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst || reset_cause) begin
      state_q <= ST_IDLE;
      stack_cnt_q <= STACK_PC_LOW;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (trap_q || (irq_request && !mask_q)) begin
            state_q <= ST_FINISH; // RULE4 RULE13
          end
        end
        ST_FINISH: begin
          if (instr_boundary) begin
            state_q <= ST_STACK; // RULE4
            stack_cnt_q <= STACK_PC_LOW;
          end
        end
        ST_STACK: begin
          if (stack_cnt_q == STACK_CCR) begin
            state_q <= ST_FETCH_HIGH; // RULE6
          end
          stack_cnt_q <= stack_cnt_q + 3'h1; // RULE5
        end
        ST_FETCH_HIGH: state_q <= ST_FETCH_LOW;
        ST_FETCH_LOW: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Vector chosen on the same edge that sets the mask, from sources pending then
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_vec_q <= VEC_RESET;
    end else if (state_q == ST_STACK && stack_cnt_q == STACK_CCR) begin
      sel_vec_q <= any_pending ? best_vec : VEC_SOFTWARE_TRAP; // RULE6
    end
  end

  always_comb begin
    mem_read = 1'b0;
    mem_write = 1'b0;
    mem_addr = 16'h0000;
    if (state_q == ST_STACK) begin
      mem_write = 1'b1;
    end else if (state_q == ST_FETCH_HIGH) begin
      mem_read = 1'b1;
      mem_addr = vector_address(sel_vec_q); // RULE1
    end else if (state_q == ST_FETCH_LOW) begin
      mem_read = 1'b1;
      mem_addr = vector_address(sel_vec_q) + 16'h0001; // RULE1
    end
  end
  assign stack_select = stack_cnt_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      vec_high_q <= 8'h00;
      program_counter <= 16'h0000;
      pc_load <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      if (reset_cause) begin
        program_counter <= vector_address(VEC_RESET); // RULE11
        pc_load <= 1'b1;
      end else if (state_q == ST_FETCH_HIGH) begin
        vec_high_q <= mem_rdata;
      end else if (state_q == ST_FETCH_LOW) begin
        program_counter <= {vec_high_q, mem_rdata}; // RULE7
        pc_load <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Status, mask and register reads
  // ************************************************************
  logic [7:0] status_set;
  assign status_set = {5'h00, reset_cause, pc_load && !reset_cause, software_trap};

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 8'h00;
    end else if (reg_read && reg_addr == REG_STATUS) begin
      status_q <= status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_reg_q <= 8'h00;
    end else if (reg_write && reg_addr == REG_MASK) begin
      mask_reg_q <= reg_wdata;
    end
  end
  assign irq = |(status_q & mask_reg_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        REG_FLAGS_LO: reg_rdata <= flags_q[7:0];
        REG_FLAGS_HI: reg_rdata <= {6'h00, flags_q[9:8]};
        REG_ENABLE_LO: reg_rdata <= enables_q[7:0];
        REG_ENABLE_HI: reg_rdata <= {6'h00, enables_q[9:8]};
        REG_STATUS: reg_rdata <= status_q;
        REG_MASK: reg_rdata <= mask_reg_q;
        REG_VECTOR: reg_rdata <= {3'h0, sel_vec_q};
        REG_CONTROL: reg_rdata <= {3'h0, state_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_flag_sets: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE2
    source_event != '0 |=> (flags_q & $past(source_event)) == $past(source_event))
    else $error("event did not set flag");
  a_request_qual: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE3
    (state_q == ST_IDLE && !trap_q && (flags_q & enables_q) == '0) |=> state_q == ST_IDLE)
    else $error("entry without qualified request");
  a_mask_blocks: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE4
    (state_q == ST_IDLE && mask_q && !trap_q) |=> state_q == ST_IDLE) else $error("masked entry");
  a_stack_order: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE5
    (state_q == ST_FINISH && instr_boundary) |=> stack_select == STACK_PC_LOW ##1 stack_select == STACK_PC_HIGH
    ##1 stack_select == STACK_INDEX ##1 stack_select == STACK_ACCUM ##1 stack_select == STACK_CCR)
    else $error("stack order wrong");
  a_mask_then_fetch: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE6
    $rose(state_q == ST_FETCH_HIGH) |-> mask_q) else $error("fetch before mask");
  a_vector_pair: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE1
    state_q == ST_FETCH_HIGH |=> mem_addr == $past(mem_addr) + 16'h0001) else $error("vector bytes");
  a_pc_loaded: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE7
    state_q == ST_FETCH_LOW |=> pc_load && program_counter == {vec_high_q, $past(mem_rdata)})
    else $error("pc not loaded");
  a_reset_mask: assert property (@(posedge clk) $past(rst) |-> mask_q) else $error("mask clear after reset"); // RULE12
  a_trap_enters: assert property (@(posedge clk) disable iff (rst || reset_cause) // RULE13
    (state_q == ST_IDLE && trap_q) |=> state_q == ST_FINISH) else $error("trap ignored");
  c_irq_entry: cover property (@(posedge clk) state_q == ST_FETCH_LOW && sel_vec_q == VEC_REQUEST_PIN);
  c_trap_entry: cover property (@(posedge clk) state_q == ST_FETCH_LOW && sel_vec_q == VEC_SOFTWARE_TRAP);
  c_reset_vector: cover property (@(posedge clk) reset_cause && !rst);

endmodule
`default_nettype wire

// *** src/irq_vector_pkg.sv ***
/*
  Constants for the interrupt qualification and vector selection logic:
  vector map, source numbers, stacking order and state encodings.
  Assumes a single 200 MHz bus clock and a synchronous active-high reset.
*/
package irq_vector_pkg;

  localparam int NUM_VECTORS = 32;
  localparam logic [15:0] VECTOR_BASE = 16'hffc0;
  localparam logic [4:0] VEC_PERIODIC_WAKEUP = 5'h17;
  localparam logic [4:0] VEC_CONVERSION = 5'h13;
  localparam logic [4:0] VEC_KEYPAD = 5'h12;
  localparam logic [4:0] VEC_TIMER_TWO_OVF = 5'h0a;
  localparam logic [4:0] VEC_TIMER_TWO_CH0 = 5'h08;
  localparam logic [4:0] VEC_TIMER_ONE_OVF = 5'h07;
  localparam logic [4:0] VEC_TIMER_ONE_CH1 = 5'h06;
  localparam logic [4:0] VEC_TIMER_ONE_CH0 = 5'h05;
  localparam logic [4:0] VEC_REQUEST_PIN = 5'h03;
  localparam logic [4:0] VEC_LOW_VOLTAGE = 5'h02;
  localparam logic [4:0] VEC_SOFTWARE_TRAP = 5'h01;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam int NUM_SOURCES = 10;
  localparam logic [NUM_SOURCES-1:0] FLAGS_RESET = 10'h000;
  localparam logic [NUM_SOURCES-1:0] ENABLES_RESET = 10'h000;
  localparam logic GLOBAL_MASK_RESET = 1'b1;
  localparam logic [2:0] STACK_BYTES = 3'h5;
  localparam logic [2:0] STACK_PC_LOW = 3'h0;
  localparam logic [2:0] STACK_PC_HIGH = 3'h1;
  localparam logic [2:0] STACK_INDEX = 3'h2;
  localparam logic [2:0] STACK_ACCUM = 3'h3;
  localparam logic [2:0] STACK_CCR = 3'h4;
  localparam logic [7:0] REG_FLAGS_LO = 8'h00;
  localparam logic [7:0] REG_FLAGS_HI = 8'h01;
  localparam logic [7:0] REG_ENABLE_LO = 8'h02;
  localparam logic [7:0] REG_ENABLE_HI = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h05;
  localparam logic [7:0] REG_VECTOR = 8'h06;
  localparam logic [7:0] REG_CONTROL = 8'h07;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FINISH = 5'b00010,
    ST_STACK = 5'b00100,
    ST_FETCH_HIGH = 5'b01000,
    ST_FETCH_LOW = 5'b10000
  } seq_state_type;

endpackage

// *** verif/core_memory_model.sv ***
/*
  Partner model of the processor core: instruction boundaries and vector memory.
  Assumes mem_addr and mem_read from irq_vector_logic; read data in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module core_memory_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] instr_len,
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  output logic [7:0] mem_rdata,
  output logic instr_boundary
);
  logic [3:0] step_q;
  logic [7:0] noise_q;
  // ************************************
  // Instructions last instr_len+1 cycles
  // ************************************
  always_ff @(posedge clk) begin
    if (rst || step_q >= instr_len) begin
      step_q <= 4'h0;
    end else begin
      step_q <= step_q + 4'h1;
    end
  end
  assign instr_boundary = (step_q >= instr_len);
  // Bus not read shows a changing pattern
  always_ff @(posedge clk) begin
    if (rst) begin
      noise_q <= 8'h96;
    end else begin
      noise_q <= noise_q + 8'h3b;
    end
  end
  // Vector image, high byte of a routine address at the even address
  assign mem_rdata = mem_read ? (mem_addr[7:0] ^ 8'h5a) : noise_q;
endmodule
`default_nettype wire

// *** verif/tb_interrupt_vector_priority_logic.sv ***
/*
  Self-checking testbench for irq_vector_logic, one task per scenario.
  Assumes core_memory_model as the processor core and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_vector_priority_logic
  import irq_vector_pkg::*;
;
  logic clk, rst, software_trap, mask_clear, reg_write, reg_read, instr_boundary;
  logic mem_read, mem_write, pc_load, global_mask, irq_request, system_reset, irq;
  logic [NUM_SOURCES-1:0] source_event;
  logic [5:0] cause;
  logic [2:0] cen, stack_select;
  logic [3:0] instr_len;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mem_rdata;
  logic [15:0] mem_addr, program_counter;
  int errors, tests_run;
  int vec_of [10] = '{23, 19, 18, 10, 8, 7, 6, 5, 3, 2};

  irq_vector_logic irq_vector_logic_inst (.clk(clk), .rst(rst), .source_event(source_event),
    .software_trap(software_trap), .instr_boundary(instr_boundary), .mask_clear(mask_clear),
    .watchdog_expired(cause[0]), .watchdog_enable(cen[0]), .low_voltage_trip(cause[1]),
    .low_voltage_reset_enable(cen[1]), .reset_pin(cause[2]), .reset_pin_enable(cen[2]),
    .illegal_opcode(cause[3]), .illegal_address(cause[4]), .power_on(cause[5]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_read(mem_read), .mem_write(mem_write),
    .stack_select(stack_select), .program_counter(program_counter), .pc_load(pc_load),
    .global_mask(global_mask), .irq_request(irq_request), .system_reset(system_reset), .irq(irq));
  core_memory_model core_memory_model_inst (.clk(clk), .rst(rst), .instr_len(instr_len),
    .mem_addr(mem_addr), .mem_read(mem_read), .mem_rdata(mem_rdata), .instr_boundary(instr_boundary));

  // *******
  // Helpers
  // *******
  task automatic print_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic give_up();
    errors++;
    print_verdict();
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic pulse_src(input logic [NUM_SOURCES-1:0] bits);
    @(posedge clk);
    source_event <= bits;
    @(posedge clk);
    source_event <= '0;
  endtask
  task automatic unmask();
    @(posedge clk);
    mask_clear <= 1'b1;
    @(posedge clk);
    mask_clear <= 1'b0;
  endtask
  task automatic clr_flag(input int i);
    reg_wr(i < 8 ? REG_FLAGS_LO : REG_FLAGS_HI, 8'h01 << (i % 8));
  endtask
  // Follows one entry sequence and judges stacking, fetch and new program counter
  task automatic run_entry(input int n);
    logic [15:0] a, pc;
    logic pb;
    int ns, nr;
    a = 16'hffc0 + 16'(2 * (31 - n));
    pc = {a[7:0] ^ 8'h5a, (a[7:0] + 8'h01) ^ 8'h5a};
    pb = 1'b0;
    ns = 0;
    nr = 0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      if (mem_write === 1'b1) begin
        if (ns == 0) check(16'(pb), 16'h1);
        check(16'(stack_select), 16'(ns));
        ns++;
      end
      if (mem_read === 1'b1) begin
        check(16'(global_mask), 16'h1);
        check(mem_addr, a + 16'(nr));
        nr++;
      end
      if (pc_load === 1'b1) begin
        check(program_counter, pc);
        check(16'(ns * 8 + nr), 16'h2a);
        return;
      end
      pb = instr_boundary;
    end
    give_up();
  endtask

  // *********
  // Scenarios
  // *********
  task automatic t_local_enable();
    logic [7:0] d;
    int busy;
    pulse_src(10'h004);
    reg_rd(REG_FLAGS_LO, d);
    check(16'(d[2]), 16'h1);
    check(16'(irq_request), 16'h0);
    reg_wr(REG_ENABLE_LO, 8'h04);
    @(negedge clk);
    check(16'(irq_request), 16'h1);
    busy = 0;
    repeat (20) begin
      @(negedge clk);
      if (mem_write !== 1'b0 || mem_read !== 1'b0) busy++;
    end
    check(16'(busy), 16'h0);
    instr_len <= 4'h7;
    unmask();
    run_entry(18);
    reg_wr(REG_FLAGS_LO, 8'h04);
    @(negedge clk);
    check(16'(irq_request), 16'h0);
  endtask
  task automatic t_sources();
    instr_len <= 4'h0;
    reg_wr(REG_ENABLE_LO, 8'hff);
    reg_wr(REG_ENABLE_HI, 8'h03);
    for (int i = 0; i < NUM_SOURCES; i++) begin
      pulse_src(10'h001 << i);
      unmask();
      run_entry(vec_of[i]);
      clr_flag(i);
    end
    pulse_src(10'h081);
    unmask();
    run_entry(5);
    clr_flag(7);
    unmask();
    run_entry(23);
    clr_flag(0);
  endtask
  task automatic t_trap_and_irq();
    logic [7:0] d;
    @(posedge clk);
    software_trap <= 1'b1;
    @(posedge clk);
    software_trap <= 1'b0;
    run_entry(1);
    reg_rd(REG_VECTOR, d);
    check(16'(d), 16'(VEC_SOFTWARE_TRAP));
    reg_wr(REG_MASK, 8'h02);
    @(negedge clk);
    check(16'(irq), 16'h1);
    reg_wr(REG_MASK, 8'h00);
    @(negedge clk);
    check(16'(irq), 16'h0);
    reg_rd(REG_STATUS, d);
    check(16'(d[1:0]), 16'h3);
    reg_wr(REG_MASK, 8'h02);
    @(negedge clk);
    check(16'(irq), 16'h0);
    reg_rd(8'h40, d);
    check(16'(d), 16'h0);
  endtask
  task automatic t_reset_causes();
    logic [7:0] d;
    int hits;
    for (int i = 0; i < 9; i++) begin
      unmask();
      cen <= (i < 6) ? 3'h7 : 3'h0;
      cause <= 6'h01 << (i % 6);
      @(negedge clk);
      check(16'(system_reset), (i < 6) ? 16'h1 : 16'h0);
      @(posedge clk);
      cause <= 6'h00;
      hits = 0;
      repeat (10) begin
        @(negedge clk);
        if (pc_load === 1'b1) begin
          hits++;
          check(program_counter, 16'hfffe);
          check(16'(global_mask), 16'h1);
        end
      end
      check(16'(hits), (i < 6) ? 16'h1 : 16'h0);
    end
    reg_rd(REG_STATUS, d);
    check(16'(d[2]), 16'h1);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    software_trap = 1'b0;
    mask_clear = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    source_event = '0;
    cause = 6'h00;
    cen = 3'h0;
    instr_len = 4'h2;
    errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(16'(global_mask), 16'h1);
    check(16'(irq_request), 16'h0);
    t_local_enable();
    t_sources();
    t_trap_and_irq();
    t_reset_causes();
    print_verdict();
  end
endmodule
`default_nettype wire
